// ===== boot_port_pkg.sv
package boot_port_pkg;

    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_PAGE_READ    = 8'hFF;
    localparam logic [7:0] CMD_PAGE_PROG    = 8'h41;
    localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
    localparam logic [7:0] CMD_ERASE_ALL    = 8'hA7;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_LOCK    = 8'h71;
    localparam logic [7:0] CMD_LOCK_PROG    = 8'h77;
    localparam logic [7:0] CMD_LOCK_ENABLE  = 8'h7A;
    localparam logic [7:0] CMD_LOCK_DISABLE = 8'h75;
    localparam logic [7:0] CMD_ID_CHECK     = 8'hF5;
    localparam logic [7:0] CMD_VERSION      = 8'hFB;
    localparam logic [7:0] CMD_BOOT_READ    = 8'hFC;
    localparam logic [7:0] CONFIRM_CODE     = 8'hD0;

    // ==========================================================
    // Sizes, counts and slot positions
    localparam int         MEM_AW         = 13;
    localparam int         MEM_WORDS      = 8192;
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam logic [7:0] OFFSET_LAST    = 8'hFF;
    localparam logic [11:0] ERASE_LAST    = 12'hFFF;
    localparam logic [3:0] SLOT_FIRST     = 4'h1;
    localparam logic [3:0] SLOT_ADDR_MID  = 4'h1;
    localparam logic [3:0] SLOT_SECONDARY_STATUS_BYTE      = 4'h1;
    localparam logic [3:0] VER_LAST       = 4'h8;
    localparam logic [3:0] ID_FIRST       = 4'h5;
    localparam logic [3:0] ID_LAST        = 4'hB;
    localparam logic [1:0] MODE_SAMPLE    = 2'h2;

    // ==========================================================
    // Status layout and reset values
    localparam int         SR_READY       = 7;
    localparam int         SR_ERR_LSB     = 3;
    localparam int         ERR_SEQ        = 0;
    localparam int         ERR_PROG       = 1;
    localparam int         ERR_ERASE      = 2;
    localparam int         SR1_ID_OK      = 3;
    localparam int         SR1_BLANK      = 2;
    localparam int         LOCK_BIT_POS   = 6;
    localparam logic [15:0] LOCK_RST      = 16'hFFFF;
    localparam logic       LOCK_EN_RST    = 1'b1;
    localparam logic [7:0] ERASED_BYTE    = 8'hFF;
    localparam logic [7:0] TX_RST         = 8'hFF;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_CONFIRM, ST_RD_OUT, ST_WR_IN,
        ST_STAT, ST_LOCK_OUT, ST_VER, ST_ID, ST_ERASE
    } st_t;

endpackage

// ===== flash_byte_store.sv
module flash_byte_store
    import boot_port_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Write port
    input  wire logic              we,
    input  wire logic [MEM_AW-1:0] waddr,
    input  wire logic [7:0]        wdata,
    // Read port
    input  wire logic [MEM_AW-1:0] raddr,
    output logic [7:0]             rdata_q
);

    logic [7:0] mem [0:MEM_WORDS-1];
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = mem[raddr];
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= rdata_d;
    end

endmodule // flash_byte_store

// ===== serial_boot_flash_command_port.sv
module serial_boot_flash_command_port
    import boot_port_pkg::*;
#(
    // Arbitrary neutral values.
    parameter logic [55:0] ID_CODE      = 56'h07_06_05_04_03_02_01,
    parameter logic [63:0] VERSION_DATA = 64'h08_07_06_05_04_03_02_01
)(
    // Core clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Serial link
    input  wire logic serial_transfer_clock_in,
    input  wire logic serial_receive_line,
    output logic      serial_transmit_line,
    output logic      busy_handshake_out,
    // Mode strap, the clock pin level seen as data
    input  wire logic mode_select_clock_pin,
    output logic      mode1_active
);

    // ==========================================================
    // Link domain
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, rxb_q, rxb_d;
    logic       tog_q, tog_d, act_q, act_d, txd_q, txd_d;
    logic [7:0] tx_q, tx_d;

    always_comb begin
        sh_d  = {serial_receive_line, sh_q[7:1]};
        bit_d = bit_q + 3'h1;
        rxb_d = rxb_q;
        tog_d = tog_q;
        act_d = (bit_d != 3'h0);
        if (bit_q == BIT_LAST) begin
            rxb_d = sh_d;
            tog_d = ~tog_q;
        end
    end

    always_ff @(posedge serial_transfer_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            bit_q <= 3'h0;
            sh_q  <= 8'h00;
            rxb_q <= 8'h00;
            tog_q <= 1'b0;
            act_q <= 1'b0;
        end else begin
            bit_q <= bit_d;
            sh_q  <= sh_d;
            rxb_q <= rxb_d;
            tog_q <= tog_d;
            act_q <= act_d;
        end
    end

    // The core only changes tx_q while busy is high, so the link reads it as a static word.
    // Falling edge transmit.
    always_comb begin
        txd_d = tx_q[bit_q];
    end

    always_ff @(negedge serial_transfer_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            txd_q <= 1'b1;
        end else begin
            txd_q <= txd_d;
        end
    end

    assign serial_transmit_line = txd_q;

    // ==========================================================
    // Crossings into the core domain
    logic [2:0] tog_s_q, act_s_q;
    logic [1:0] mode_s_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tog_s_q  <= 3'h0;
            act_s_q  <= 3'h0;
            mode_s_q <= 2'h0;
        end else begin
            tog_s_q  <= {tog_s_q[1:0], tog_q};
            act_s_q  <= {act_s_q[1:0], act_q};
            mode_s_q <= {mode_s_q[0], mode_select_clock_pin};
        end
    end

    logic evt, act_rise;
    assign evt      = (tog_s_q[1] ^ tog_s_q[2]) & mode1_active;
    assign act_rise = act_s_q[1] & ~act_s_q[2];

    // ==========================================================
    // Command state
    st_t         st_q, st_d;
    logic [7:0]  cmd_q, cmd_d, off_q, off_d;
    logic [3:0]  slot_q, slot_d;
    logic [15:0] addr_q, addr_d, lock_q, lock_d;
    logic [2:0]  err_q, err_d;
    logic [11:0] era_q, era_d;
    logic [1:0]  load_q, load_d, cap_q, cap_d;
    logic        lock_en_q, lock_en_d, full_q, full_d, id_ok_q, id_ok_d;
    logic        match_q, match_d, era_all_q, era_all_d;
    logic        hold_q, hold_d, busy_q, busy_d, mode1_q, mode1_d;
    logic        we, allowed, open_cmd, blk_open, era_open;
    logic [MEM_AW-1:0] waddr, raddr;
    logic [7:0]  wdata, rdata, primary_status_byte, secondary_status_byte;
    logic [3:0]  blk;
    logic [2:0]  id_ix;

    assign blk      = addr_q[3:0];
    assign blk_open = lock_q[blk] | ~lock_en_q;
    assign era_open = lock_q[era_q[11:8]] | ~lock_en_q;
    assign id_ix    = 3'(slot_q - ID_FIRST);
    assign raddr    = {cmd_q == CMD_BOOT_READ, blk, off_q};
    // Blank flash or matched code opens protected commands.
    assign allowed  = ~full_q | id_ok_q;
    assign open_cmd = (rxb_q == CMD_READ_STATUS) | (rxb_q == CMD_ID_CHECK) | (rxb_q == CMD_VERSION);

    always_comb begin
        primary_status_byte = 8'h00;
        primary_status_byte[SR_READY] = (st_q != ST_ERASE);
        primary_status_byte[SR_ERR_LSB +: 3] = err_q;
        secondary_status_byte = 8'h00;
        secondary_status_byte[SR1_ID_OK] = id_ok_q;
        secondary_status_byte[SR1_BLANK] = ~full_q;
    end

    always_comb begin
        st_d = st_q;     cmd_d = cmd_q;     slot_d = slot_q;   addr_d = addr_q;
        off_d = off_q;   tx_d = tx_q;       err_d = err_q;     lock_d = lock_q;
        lock_en_d = lock_en_q;  full_d = full_q;  id_ok_d = id_ok_q;  match_d = match_q;
        era_d = era_q;   era_all_d = era_all_q;
        load_d = {load_q[0], 1'b0};
        we = 1'b0;
        waddr = {1'b0, blk, off_q};
        wdata = rxb_q;
        if (load_q[1]) begin
            tx_d = rdata;
        end
        // Only a received byte moves the command machine, except the erase sweep, which returns it to ST_IDLE.
        if (evt) begin
            case (st_q)
                ST_IDLE: begin
                    cmd_d  = rxb_q;
                    slot_d = SLOT_FIRST;
                    off_d  = 8'h00;
                    if (open_cmd || allowed) begin
                        case (rxb_q)
                            CMD_PAGE_READ, CMD_PAGE_PROG, CMD_BLOCK_ERASE,
                            CMD_READ_LOCK, CMD_LOCK_PROG, CMD_BOOT_READ: st_d = ST_ADDR;
                            CMD_ERASE_ALL: st_d = ST_CONFIRM;
                            CMD_READ_STATUS: begin
                                st_d = ST_STAT;
                                tx_d = primary_status_byte;
                            end
                            CMD_CLEAR_STATUS: err_d = 3'h0;
                            CMD_LOCK_ENABLE: lock_en_d = 1'b1;
                            CMD_LOCK_DISABLE: lock_en_d = 1'b0;
                            CMD_VERSION: begin
                                st_d = ST_VER;
                                tx_d = VERSION_DATA[7:0];
                            end
                            CMD_ID_CHECK: begin
                                st_d    = ST_ID;
                                match_d = 1'b1;
                            end
                            default: st_d = ST_IDLE;
                        endcase
                    end
                end
                ST_ADDR: begin
                    slot_d = slot_q + 4'h1;
                    if (slot_q == SLOT_ADDR_MID) begin
                        addr_d[7:0] = rxb_q;
                    end else begin
                        addr_d[15:8] = rxb_q;
                        case (cmd_q)
                            CMD_PAGE_READ, CMD_BOOT_READ: begin
                                st_d      = ST_RD_OUT;
                                load_d[0] = 1'b1;
                            end
                            CMD_PAGE_PROG: st_d = ST_WR_IN;
                            CMD_READ_LOCK: begin
                                st_d = ST_LOCK_OUT;
                                tx_d = 8'h00;
                                tx_d[LOCK_BIT_POS] = lock_q[blk];
                            end
                            default: st_d = ST_CONFIRM;
                        endcase
                    end
                end
                ST_RD_OUT: begin
                    off_d = off_q + 8'h01;
                    if (off_q == OFFSET_LAST) begin
                        st_d = ST_IDLE;
                    end else begin
                        load_d[0] = 1'b1;
                    end
                end
                ST_WR_IN: begin
                    off_d  = off_q + 8'h01;
                    full_d = 1'b1;
                    if (blk_open) begin
                        we = 1'b1;
                    end else begin
                        err_d[ERR_PROG] = 1'b1;
                    end
                    if (off_q == OFFSET_LAST) begin
                        st_d = ST_IDLE;
                    end
                end
                ST_CONFIRM: begin
                    st_d = ST_IDLE;
                    if (rxb_q != CONFIRM_CODE) begin
                        err_d[ERR_SEQ] = 1'b1;
                    end else if (cmd_q == CMD_LOCK_PROG) begin
                        lock_d[blk] = 1'b0;
                    end else if (cmd_q == CMD_BLOCK_ERASE && !blk_open) begin
                        err_d[ERR_ERASE] = 1'b1;
                    end else begin
                        st_d      = ST_ERASE;
                        era_d     = 12'h000;
                        era_all_d = (cmd_q == CMD_ERASE_ALL);
                    end
                end
                ST_STAT: begin
                    slot_d = slot_q + 4'h1;
                    tx_d   = secondary_status_byte;
                    if (slot_q != SLOT_SECONDARY_STATUS_BYTE) begin
                        st_d = ST_IDLE;
                    end
                end
                ST_LOCK_OUT: st_d = ST_IDLE;
                // Version bytes to the eighth slot.
                ST_VER: begin
                    slot_d = slot_q + 4'h1;
                    tx_d   = VERSION_DATA[{slot_q[2:0], 3'b000} +: 8];
                    if (slot_q == VER_LAST) begin
                        st_d = ST_IDLE;
                    end
                end
                ST_ID: begin
                    slot_d = slot_q + 4'h1;
                    if (slot_q >= ID_FIRST) begin
                        match_d = match_q & (rxb_q == ID_CODE[{id_ix, 3'b000} +: 8]);
                    end
                    if (slot_q == ID_LAST) begin
                        id_ok_d = match_d;
                        st_d    = ST_IDLE;
                    end
                end
                ST_ERASE: st_d = ST_ERASE;
                default: st_d = ST_IDLE;
            endcase
        end
        // Sweep the user area; locked blocks are skipped while lock bits are enabled.
        if (st_q == ST_ERASE) begin
            era_d = era_q + 12'h001;
            waddr = {1'b0, era_q};
            wdata = ERASED_BYTE;
            we    = (era_all_q || era_q[11:8] == blk) && era_open;
            if (era_q == ERASE_LAST) begin
                st_d = ST_IDLE;
                if (era_all_q && (!lock_en_q || &lock_q)) begin
                    full_d = 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Mode strap and busy
    always_comb begin
        cap_d   = cap_q;
        mode1_d = mode1_q;
        // Latch the strap once, after the synchroniser has settled.
        if (cap_q != 2'h3) begin
            cap_d = cap_q + 2'h1;
        end
        if (cap_q == MODE_SAMPLE) begin
            mode1_d = mode_s_q[1];
        end
        // A new byte starts only after busy falls, and busy stays high until the byte end's evt, so they never collide.
        hold_d = evt ? 1'b0 : (hold_q | act_rise);
        // Busy covers link activity, pending bytes, fetches and erase.
        busy_d = ~mode1_d | act_s_q[1] | hold_d | evt | (|load_d) | (st_d == ST_ERASE);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;    cmd_q <= 8'h00;     slot_q <= 4'h0;     addr_q <= 16'h0000;
            off_q <= 8'h00;     tx_q <= TX_RST;     err_q <= 3'h0;      lock_q <= LOCK_RST;
            lock_en_q <= LOCK_EN_RST;  full_q <= 1'b0;  id_ok_q <= 1'b0;  match_q <= 1'b0;
            era_q <= 12'h000;   era_all_q <= 1'b0;  load_q <= 2'h0;     cap_q <= 2'h0;
            mode1_q <= 1'b0;    hold_q <= 1'b0;     busy_q <= 1'b1;
        end else begin
            st_q <= st_d;       cmd_q <= cmd_d;     slot_q <= slot_d;   addr_q <= addr_d;
            off_q <= off_d;     tx_q <= tx_d;       err_q <= err_d;     lock_q <= lock_d;
            lock_en_q <= lock_en_d;  full_q <= full_d;  id_ok_q <= id_ok_d;  match_q <= match_d;
            era_q <= era_d;     era_all_q <= era_all_d;  load_q <= load_d;  cap_q <= cap_d;
            mode1_q <= mode1_d; hold_q <= hold_d;   busy_q <= busy_d;
        end
    end

    assign busy_handshake_out = busy_q;
    assign mode1_active       = mode1_q;

    flash_byte_store u_store (
        .clk     (mclk),
        .we      (we),
        .waddr   (waddr),
        .wdata   (wdata),
        .raddr   (raddr),
        .rdata_q (rdata)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic idle_cmd;
    assign idle_cmd = evt && st_q == ST_IDLE;

    a_busy_erase: assert property (
        st_q == ST_ERASE |-> busy_handshake_out)
        else $error("busy low during erase");
    a_clear_flags: assert property (
        idle_cmd && allowed && rxb_q == CMD_CLEAR_STATUS |=> err_q == 3'h0)
        else $error("error flags not cleared");
    a_clear_release: assert property (
        idle_cmd && allowed && rxb_q == CMD_CLEAR_STATUS |=> busy_handshake_out ##[1:6] !busy_handshake_out)
        else $error("busy did not fall after clear");
    a_status_first: assert property (
        idle_cmd && rxb_q == CMD_READ_STATUS |=> tx_q == $past(primary_status_byte) && st_q == ST_STAT)
        else $error("primary status not loaded");
    a_refuse_locked: assert property (
        idle_cmd && !allowed && rxb_q == CMD_PAGE_READ |=> st_q == ST_IDLE)
        else $error("protected command accepted");
    a_blank_accept: assert property (
        idle_cmd && !full_q && rxb_q == CMD_PAGE_PROG |=> st_q == ST_ADDR)
        else $error("blank flash refused command");
    a_read_fetch: assert property (
        evt && st_q == ST_RD_OUT && off_q != OFFSET_LAST
        |=> off_q == $past(off_q) + 8'h01 ##2 tx_q == $past(rdata))
        else $error("page byte not loaded in order");
    a_prog_write: assert property (
        evt && st_q == ST_WR_IN && blk_open |-> we && wdata == rxb_q)
        else $error("program byte not written");
    a_page_end: assert property (
        evt && (st_q == ST_RD_OUT || st_q == ST_WR_IN) && off_q == OFFSET_LAST |=> st_q == ST_IDLE)
        else $error("page command did not end");
    a_ver_len: assert property (
        evt && st_q == ST_VER && slot_q == VER_LAST |=> st_q == ST_IDLE)
        else $error("version stream wrong length");

    c_page_read: cover property (evt && st_q == ST_RD_OUT && off_q == OFFSET_LAST);
    c_erase_all: cover property (st_q == ST_ERASE && era_all_q && era_q == ERASE_LAST);
    c_id_ok: cover property (evt && st_q == ST_ID && slot_q == ID_LAST && match_d);

endmodule // serial_boot_flash_command_port

// ===== boot_programmer_model.sv
// ==========================================================
// Serial programmer model
module boot_programmer_model (
    // Serial link
    output logic      sclk,
    output logic      rxd,
    input  wire logic txd,
    input  wire logic busy
);
    timeunit 1ns;
    timeprecision 100ps;

    // The clock idles high, so the strap reads mode 1 at reset release.
    initial begin
        sclk = 1'b1;
        rxd  = 1'b1;
    end

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output bit late);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20000) begin
            n++;
            #2;
        end
        for (int i = 0; i < 8; i++) begin
            sclk  = 1'b0;
            rxd   = tx[i];
            #6;
            sclk  = 1'b1;
            rx[i] = txd;
            #6;
        end
        // The line is not held after the byte, so a stale bit is never left on it.
        rxd = ~tx[7];
        while (busy !== 1'b0 && n < 20000) begin
            n++;
            #2;
        end
        late = (n >= 20000);
    endtask
endmodule // boot_programmer_model

// ===== serial_boot_flash_command_port_tb_top.sv
// ==========================================================
// Testbench
module serial_boot_flash_command_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import boot_port_pkg::*;

    localparam logic [63:0] VER = 64'h88_77_66_55_44_33_22_11;
    // Arbitrary identification value.
    localparam logic [55:0] IDC = 56'h7E_6D_5C_4B_3A_29_18;

    typedef struct {logic [7:0] cmd; int n; logic [63:0] exp;} row_t;

    logic       mclk  = 1'b0;
    logic       rst_n = 1'b1;
    wire logic  sclk;
    wire logic  rxd;
    logic       txd;
    logic       busy;
    logic       m1;
    logic [7:0] got;
    int         failures    = 0;
    int         check_count = 0;
    row_t       rows[2] = '{'{CMD_VERSION, 8, VER}, '{CMD_READ_STATUS, 2, 64'h04_80}};

    always #4 mclk = ~mclk;

    serial_boot_flash_command_port #(.ID_CODE(IDC), .VERSION_DATA(VER)) i_dut (
        .mclk                     (mclk),
        .rst_n                    (rst_n),
        .serial_transfer_clock_in (sclk),
        .serial_receive_line      (rxd),
        .serial_transmit_line     (txd),
        .busy_handshake_out       (busy),
        .mode_select_clock_pin    (sclk),
        .mode1_active             (m1)
    );

    boot_programmer_model i_prog (
        .sclk (sclk),
        .rxd  (rxd),
        .txd  (txd),
        .busy (busy)
    );

    task automatic close_out;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic send(input logic [7:0] b);
        bit late;
        i_prog.xfer(b, got, late);
        if (late) begin
            failures++;
            $display("BAD t=%0t busy stuck %h exp %h", $time, busy, 1'b0);
        end
    endtask

    task automatic status(input logic [7:0] p, input logic [7:0] s);
        send(CMD_READ_STATUS);
        send(8'h00);
        check_byte(got, p);
        send(8'h00);
        check_byte(got, s);
    endtask

    task automatic blk_erase;
        send(CMD_BLOCK_ERASE);
        send(8'h03);
        send(8'h00);
        send(CONFIRM_CODE);
    endtask

    task automatic page(input logic [7:0] cmd, input bit erased);
        send(cmd);
        send(8'h03);
        send(8'h00);
        for (int i = 0; i < 256; i++) begin
            send(cmd == CMD_PAGE_PROG ? (i[7:0] ^ 8'hA5) : 8'h00);
            if (cmd == CMD_PAGE_READ) check_byte(got, erased ? 8'hFF : (i[7:0] ^ 8'hA5));
        end
    endtask

    // A hang in the handshake must still end the run with a verdict.
    initial begin
        #500us;
        failures++;
        close_out();
    end

    initial begin
        // Reset falls after time zero, so the asynchronous flops see a real edge.
        #1;
        rst_n = 1'b0;
        repeat (12) @(negedge mclk);
        check_byte({5'h00, busy, txd, m1}, 8'h06);
        rst_n = 1'b1;
        repeat (50) @(negedge mclk) if (busy === 1'b0) break;
        check_byte({7'h00, m1}, 8'h01);
        foreach (rows[r]) begin
            send(rows[r].cmd);
            for (int i = 0; i < rows[r].n; i++) begin
                send(8'h00);
                check_byte(got, rows[r].exp[8*i +: 8]);
            end
        end
        page(CMD_PAGE_PROG, 1'b0);
        status(8'h80, 8'h00);
        // A refused read must leave the port idle, so the status read decodes.
        send(CMD_PAGE_READ);
        status(8'h80, 8'h00);
        send(CMD_ID_CHECK);
        repeat (3) send(8'h00);
        send(8'h07);
        for (int i = 0; i < 7; i++) send(IDC[8*i +: 8]);
        status(8'h80, 8'h08);
        page(CMD_PAGE_READ, 1'b0);
        send(CMD_READ_LOCK);
        send(8'h03);
        send(8'h00);
        send(8'h00);
        check_byte({7'h00, got[LOCK_BIT_POS]}, 8'h01);
        send(CMD_ERASE_ALL);
        send(8'h00);
        status(8'h88, 8'h08);
        send(CMD_CLEAR_STATUS);
        status(8'h80, 8'h08);
        send(CMD_ERASE_ALL);
        send(CONFIRM_CODE);
        status(8'h80, 8'h0C);
        page(CMD_PAGE_READ, 1'b1);
        // A locked block refuses erase until the lock bits are disabled.
        send(CMD_LOCK_PROG);
        send(8'h03);
        send(8'h00);
        send(CONFIRM_CODE);
        send(CMD_READ_LOCK);
        send(8'h03);
        send(8'h00);
        send(8'h00);
        check_byte({7'h00, got[LOCK_BIT_POS]}, 8'h00);
        blk_erase();
        status(8'hA0, 8'h0C);
        send(CMD_CLEAR_STATUS);
        send(CMD_LOCK_DISABLE);
        blk_erase();
        status(8'h80, 8'h0C);
        send(CMD_LOCK_ENABLE);
        blk_erase();
        status(8'hA0, 8'h0C);
        close_out();
    end
endmodule // serial_boot_flash_command_port_tb_top
